// ===== core/fbps_pkg.sv
// constants and types shared by the bulk factory program sequencer
`default_nettype none
package fbps_pkg;
   // ===========================================================
   // flash command codes
   localparam logic [7:0] CMD_BF_SETUP = 8'h80;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_WORD_PROG = 8'h40;
   localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY = 8'h98;
   localparam logic [15:0] PAD_WORD = 16'hffff;
   // ===========================================================
   // ahb-lite register map
   localparam logic [31:0] OFS_ADDR = 32'h0000_0000;
   localparam logic [31:0] OFS_WDATA = 32'h0000_0004;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0008;
   localparam logic [31:0] OFS_CTRL = 32'h0000_000c;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ===========================================================
   // status fields
   localparam int SR_BUSY = 0;
   localparam int SR_LOCK = 1;
   localparam int SR_SUSP = 2;
   localparam int SR_SUPPLY = 3;
   localparam int SR_PERR = 4;
   localparam int SR_READY = 7;
   localparam int SR_SESS = 8;
   localparam int SR_MODE = 10;
   // ===========================================================
   // control fields
   localparam int CTL_LOCKED = 0;
   localparam int CTL_VPP_BAD = 1;
   localparam int CTL_CE = 2;
   localparam int CTL_W = 3;
   localparam logic [2:0] CTRL_RST = 3'h4;
   // ===========================================================
   // types
   typedef enum logic [1:0] {
      RM_ARRAY = 2'h0,
      RM_STATUS = 2'h1,
      RM_ID = 2'h2,
      RM_QUERY = 2'h3
   } fbps_rmode_t;
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_BF_SETUP = 4'h1,
      S_BF_CHECK = 4'h3,
      S_BF_FILL = 4'h2,
      S_BF_PROG = 4'h6,
      S_BF_EXIT = 4'he,
      S_WP_SETUP = 4'h4,
      S_WP_BUSY = 4'h5,
      S_WP_SUSP = 4'h7
   } fbps_state_t;
endpackage : fbps_pkg
`default_nettype wire

// ===== core/fbps_sequencer.sv
// bulk factory program and program suspend sequencer with ahb-lite access
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`default_nettype none
module fbps_sequencer #(
   parameter int ADDR_W = 24,
   parameter int BLOCK_W = 16,
   parameter int BUF_WORDS = 512,
   parameter int SETUP_CYC = 8,
   parameter int WORD_CYC = 2,
   parameter int WP_CYC = 16,
   parameter int SUSP_PT = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // array write port
   output logic array_we,
   output logic [ADDR_W-1:0] array_addr,
   output logic [15:0] array_wdata,
   // power state
   output logic standby
);
   import fbps_pkg::*;

   localparam int BUF_W = $clog2(BUF_WORDS);
   localparam logic [BUF_W-1:0] BUF_LAST = BUF_W'(BUF_WORDS - 1);

   // ===========================================================
   // parameter checks
   generate
      if (ADDR_W > 32 || BLOCK_W <= BUF_W || ADDR_W <= BLOCK_W) begin : g_bad_w
         $error("fbps_sequencer: bad address widths");
      end
      if ((1 << BUF_W) != BUF_WORDS || (SUSP_PT & (SUSP_PT - 1)) != 0) begin : g_bad_p
         $error("fbps_sequencer: sizes must be powers of two");
      end
      if (SETUP_CYC < 1 || WORD_CYC < 1 || WP_CYC < 1 || WP_CYC > 65535) begin : g_bad_c
         $error("fbps_sequencer: bad cycle counts");
      end
   endgenerate

   // ===========================================================
   // ahb-lite slave
   logic ap_wr_q;
   logic [31:0] ap_addr_q;
   logic [31:0] rdata_q;
   logic [ADDR_W-1:0] faddr_q;
   logic [CTL_W-1:0] ctrl_q;
   logic [31:0] status_w;
   logic [31:0] rd_mux;

   wire ap_take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   wire wr_addr = ap_wr_q & (ap_addr_q == OFS_ADDR);
   wire wr_ctrl = ap_wr_q & (ap_addr_q == OFS_CTRL);
   wire fw_valid = ap_wr_q & (ap_addr_q == OFS_WDATA);
   wire [ADDR_W-1:0] fw_addr = faddr_q;
   wire [15:0] fw_data = hwdata[15:0];
   wire [7:0] fw_cmd = hwdata[7:0];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign rd_mux = (haddr == OFS_ADDR) ? 32'(faddr_q) :
                   (haddr == OFS_STATUS) ? status_w :
                   (haddr == OFS_CTRL) ? 32'(ctrl_q) : 32'h0000_0000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ap_wr_q <= 1'b0;
         ap_addr_q <= 32'h0000_0000;
         rdata_q <= 32'h0000_0000;
      end else begin
         ap_wr_q <= ap_take & hwrite;
         if (ap_take) begin
            ap_addr_q <= haddr;
         end
         if (ap_take & ~hwrite) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         faddr_q <= '0;
         ctrl_q <= CTRL_RST;
      end else begin
         if (wr_addr) begin
            faddr_q <= hwdata[ADDR_W-1:0];
         end
         if (wr_ctrl) begin
            ctrl_q <= hwdata[CTL_W-1:0];
         end
      end
   end

   wire blk_locked = ctrl_q[CTL_LOCKED];
   wire vpp_bad = ctrl_q[CTL_VPP_BAD];
   assign standby = ~ctrl_q[CTL_CE];

   // ===========================================================
   // sequencer state
   fbps_state_t st_q, st_d;
   fbps_rmode_t rmode_q, rmode_d, cmd_mode;
   logic [15:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] wa0_q, wa0_d, pa_q, pa_d, waddr_q, waddr_d;
   logic [BUF_W-1:0] idx_q, idx_d;
   logic [15:0] wpd_q, wpd_d, wdat_q, wdat_d;
   logic ready_q, ready_d, busy_q, busy_d, perr_q, perr_d;
   logic supply_q, supply_d, lock_q, lock_d, susp_q, susp_d;
   logic sess_q, sess_d, sreq_q, sreq_d, we_q, we_d, buf_we;
   logic [15:0] buf_q [BUF_WORDS];

   wire cnt_zero = (cnt_q == 16'h0000);
   wire pt_hit = ((cnt_q & 16'(SUSP_PT - 1)) == 16'h0000);
   wire in_block = (fw_addr[ADDR_W-1:BLOCK_W] == wa0_q[ADDR_W-1:BLOCK_W]);
   wire misalign = |wa0_q[BUF_W-1:0];
   wire chk_fail = blk_locked | vpp_bad | misalign;
   wire is_read = (fw_cmd == CMD_READ_ARRAY) | (fw_cmd == CMD_READ_STATUS) |
                  (fw_cmd == CMD_READ_ID) | (fw_cmd == CMD_READ_QUERY);
   wire is_confirm = fw_valid & (fw_cmd == CMD_CONFIRM);
   wire [BLOCK_W-1:0] pa_next = pa_q[BLOCK_W-1:0] + BLOCK_W'(1);

   assign cmd_mode = (fw_cmd == CMD_READ_STATUS) ? RM_STATUS :
                     (fw_cmd == CMD_READ_ID) ? RM_ID :
                     (fw_cmd == CMD_READ_QUERY) ? RM_QUERY : RM_ARRAY;

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[SR_BUSY] = busy_q;
      status_w[SR_LOCK] = lock_q;
      status_w[SR_SUSP] = susp_q;
      status_w[SR_SUPPLY] = supply_q;
      status_w[SR_PERR] = perr_q;
      status_w[SR_READY] = ready_q;
      status_w[SR_SESS] = sess_q;
      status_w[SR_MODE +: 2] = rmode_q;
   end

   always_comb begin
      st_d = st_q;
      rmode_d = rmode_q;
      cnt_d = cnt_q;
      wa0_d = wa0_q;
      pa_d = pa_q;
      idx_d = idx_q;
      wpd_d = wpd_q;
      ready_d = ready_q;
      busy_d = busy_q;
      perr_d = perr_q;
      supply_d = supply_q;
      lock_d = lock_q;
      susp_d = susp_q;
      sess_d = sess_q;
      sreq_d = sreq_q;
      we_d = 1'b0;
      waddr_d = waddr_q;
      wdat_d = wdat_q;
      buf_we = 1'b0;
      unique case (st_q)
         S_IDLE: begin
            if (fw_valid) begin
               if (fw_cmd == CMD_BF_SETUP) begin
                  st_d = S_BF_SETUP;
                  wa0_d = fw_addr;
               end else if (fw_cmd == CMD_WORD_PROG) begin
                  st_d = S_WP_SETUP;
               end else if (fw_cmd == CMD_CLR_STATUS) begin
                  perr_d = 1'b0;
                  supply_d = 1'b0;
                  lock_d = 1'b0;
               end else if (is_read) begin
                  rmode_d = cmd_mode;
               end
            end
         end
         S_BF_SETUP: begin
            if (is_confirm) begin
               st_d = S_BF_CHECK;
               ready_d = 1'b0;
               sess_d = 1'b0;
               rmode_d = RM_STATUS;
               cnt_d = 16'(SETUP_CYC - 1);
            end else if (fw_valid) begin
               st_d = S_IDLE;
            end
         end
         S_BF_CHECK: begin
            if (!cnt_zero) begin
               cnt_d = cnt_q - 16'h0001;
            end else if (chk_fail) begin
               perr_d = 1'b1;
               lock_d = lock_q | blk_locked;
               supply_d = supply_q | vpp_bad;
               sess_d = 1'b1;
               ready_d = 1'b1;
               st_d = S_IDLE;
            end else begin
               st_d = S_BF_FILL;
               idx_d = '0;
               pa_d = wa0_q;
               busy_d = 1'b0;
            end
         end
         S_BF_FILL: begin
            if (fw_valid) begin
               if (!in_block) begin
                  st_d = S_BF_EXIT;
                  idx_d = '0;
               end else begin
                  buf_we = 1'b1;
                  idx_d = idx_q + BUF_W'(1);
                  if (idx_q == BUF_LAST) begin
                     st_d = S_BF_PROG;
                     busy_d = 1'b1;
                     cnt_d = 16'(WORD_CYC - 1);
                  end
               end
            end
         end
         S_BF_PROG: begin
            // host writes and suspend requests have no effect here
            if (!cnt_zero) begin
               cnt_d = cnt_q - 16'h0001;
            end else begin
               we_d = 1'b1;
               waddr_d = pa_q;
               wdat_d = buf_q[idx_q];
               pa_d = {pa_q[ADDR_W-1:BLOCK_W], pa_next};
               idx_d = idx_q + BUF_W'(1);
               cnt_d = 16'(WORD_CYC - 1);
               if (idx_q == BUF_LAST) begin
                  st_d = S_BF_FILL;
                  busy_d = 1'b0;
               end
            end
         end
         S_BF_EXIT: begin
            ready_d = 1'b1;
            sess_d = sess_q | perr_q;
            st_d = S_IDLE;
         end
         S_WP_SETUP: begin
            if (fw_valid) begin
               rmode_d = RM_STATUS;
               if (blk_locked | vpp_bad) begin
                  perr_d = 1'b1;
                  lock_d = lock_q | blk_locked;
                  supply_d = supply_q | vpp_bad;
                  st_d = S_IDLE;
               end else begin
                  wa0_d = fw_addr;
                  wpd_d = fw_data;
                  ready_d = 1'b0;
                  sreq_d = 1'b0;
                  cnt_d = 16'(WP_CYC - 1);
                  st_d = S_WP_BUSY;
               end
            end
         end
         S_WP_BUSY: begin
            // also re-entered on resume from S_WP_SUSP, so stays suspendable
            if (fw_valid && fw_cmd == CMD_SUSPEND) begin
               sreq_d = 1'b1;
            end
            if (cnt_zero) begin
               we_d = 1'b1;
               waddr_d = wa0_q;
               wdat_d = wpd_q;
               ready_d = 1'b1;
               sreq_d = 1'b0;
               st_d = S_IDLE;
            end else if (sreq_q && pt_hit) begin
               st_d = S_WP_SUSP;
               ready_d = 1'b1;
               susp_d = 1'b1;
               sreq_d = 1'b0;
            end else begin
               cnt_d = cnt_q - 16'h0001;
            end
         end
         S_WP_SUSP: begin
            if (is_confirm) begin
               st_d = S_WP_BUSY;
               ready_d = 1'b0;
               susp_d = 1'b0;
               rmode_d = RM_STATUS;
            end else if (fw_valid && is_read) begin
               rmode_d = cmd_mode;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (buf_we) begin
         buf_q[idx_q] <= fw_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
         rmode_q <= RM_ARRAY;
         cnt_q <= 16'h0000;
         wa0_q <= '0;
         pa_q <= '0;
         idx_q <= '0;
         wpd_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         rmode_q <= rmode_d;
         cnt_q <= cnt_d;
         wa0_q <= wa0_d;
         pa_q <= pa_d;
         idx_q <= idx_d;
         wpd_q <= wpd_d;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_q <= 1'b1;
         busy_q <= 1'b0;
         perr_q <= 1'b0;
         supply_q <= 1'b0;
         lock_q <= 1'b0;
         susp_q <= 1'b0;
         sess_q <= 1'b0;
         sreq_q <= 1'b0;
      end else begin
         ready_q <= ready_d;
         busy_q <= busy_d;
         perr_q <= perr_d;
         supply_q <= supply_d;
         lock_q <= lock_d;
         susp_q <= susp_d;
         sess_q <= sess_d;
         sreq_q <= sreq_d;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         we_q <= 1'b0;
         waddr_q <= '0;
         wdat_q <= 16'h0000;
      end else begin
         we_q <= we_d;
         waddr_q <= waddr_d;
         wdat_q <= wdat_d;
      end
   end

   assign array_we = we_q;
   assign array_addr = waddr_q;
   assign array_wdata = wdat_q;

   // ===========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence seq_exit;
      st_q == S_BF_EXIT ##1 (st_q == S_IDLE && ready_q);
   endsequence

   sequence seq_fill_done;
      st_q == S_BF_FILL && fw_valid && in_block && idx_q == BUF_LAST;
   endsequence

   AST_ENTRY_BUSY: assert property (
      st_q == S_BF_SETUP && is_confirm |=> !ready_q && st_q == S_BF_CHECK)
      else $error("ready not cleared on bulk entry");
   AST_MISALIGN: assert property (
      st_q == S_BF_CHECK && cnt_zero && misalign |=> perr_q && st_q == S_IDLE)
      else $error("misaligned start not failed");
   AST_LOCKED: assert property (
      st_q == S_BF_CHECK && cnt_zero && blk_locked |=> perr_q && lock_q && ready_q)
      else $error("locked block not reported");
   AST_FULL_PROG: assert property (
      seq_fill_done |=> st_q == S_BF_PROG && busy_q && idx_q == '0)
      else $error("full buffer did not start programming");
   AST_IGNORE_WR: assert property (
      st_q == S_BF_PROG && fw_valid && !cnt_zero |=> st_q == S_BF_PROG && $stable(idx_q))
      else $error("write during buffer program had effect");
   AST_ADVANCE: assert property (
      st_q == S_BF_PROG && cnt_zero |=> array_we && array_addr == $past(pa_q) &&
      pa_q[BLOCK_W-1:0] == $past(pa_next) && pa_q[ADDR_W-1:BLOCK_W] == wa0_q[ADDR_W-1:BLOCK_W])
      else $error("array address did not advance within block");
   AST_OUT_BLOCK: assert property (
      st_q == S_BF_FILL && fw_valid && !in_block |=> seq_exit)
      else $error("out of block write did not exit");
   AST_NO_SUSP: assert property (
      st_q inside {S_BF_CHECK, S_BF_FILL, S_BF_PROG} |-> !susp_q && !sreq_q)
      else $error("suspend seen in bulk mode");
   AST_SUSPEND: assert property (
      st_q == S_WP_BUSY && sreq_q && pt_hit && !cnt_zero |=> ready_q && susp_q ##1 !array_we)
      else $error("suspend did not show ready and suspended");
   AST_RESUME: assert property (
      st_q == S_WP_SUSP && is_confirm |=> !ready_q && !susp_q && st_q == S_WP_BUSY)
      else $error("resume did not clear flags");
   AST_SUSP_ONLY: assert property (
      st_q == S_WP_SUSP && fw_valid && !is_confirm |=> st_q == S_WP_SUSP && $stable(perr_q))
      else $error("command taken while suspended");
endmodule : fbps_sequencer
`default_nettype wire

// ===== dv/fbps_host.sv
// ahb-lite host model that issues single word transfers to the sequencer
`default_nettype none
module fbps_host
   import fbps_pkg::*;
(
   // clock
   input wire logic clk,
   // ahb-lite master side
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
   end
   // one transfer: address phase held until hready, then data phase held until hready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask : xfer
endmodule : fbps_host
`default_nettype wire

// ===== dv/factory_buffer_program_suspend_tb_top.sv
// self-checking bench for the bulk factory program and suspend sequencer
`default_nettype none
module factory_buffer_program_suspend_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fbps_pkg::*;
   localparam int BW = 16;
   localparam int BLK = 64;
   logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, array_we, standby;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, st;
   logic [23:0] array_addr;
   logic [15:0] array_wdata, d;
   logic [39:0] exp_q[$];
   logic [31:0] fctl[3] = '{32'h5, 32'h6, 32'h4};
   logic [31:0] fadr[3] = '{32'h40, 32'h40, 32'h48};
   logic [31:0] fexp[3] = '{32'h592, 32'h598, 32'h590};
   logic [7:0] mcmd[4] = '{CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_ID, CMD_READ_QUERY};
   int err_count = 0;
   int cmp_count = 0;
   // ===========================================================
   // clock, design and host
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   fbps_sequencer #(.BLOCK_W(6), .BUF_WORDS(BW), .SETUP_CYC(6), .WORD_CYC(2), .WP_CYC(16), .SUSP_PT(2)) uut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .array_we(array_we), .array_addr(array_addr), .array_wdata(array_wdata),
      .standby(standby));
   fbps_host host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   // ===========================================================
   // helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      logic [31:0] r;
      host.xfer(1'b1, a, v, r);
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      host.xfer(1'b0, a, 32'h0, r);
   endtask : rd
   task automatic cmd(input logic [15:0] v);
      wr(OFS_WDATA, {16'h0, v});
   endtask : cmd
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      rd(OFS_STATUS, st);
      while ((st & m) !== v && n < 500) begin
         rd(OFS_STATUS, st);
         n++;
      end
      chk("status poll", v, st & m);
   endtask : poll
   task automatic end_of_test;
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // array writes are compared with the model queue in order
   always @(posedge clk) begin
      if (array_we === 1'b1) begin
         if (exp_q.size() == 0) chk("array write", 32'h0, 32'h1);
         else begin
            chk("array addr", 32'(exp_q[0][39:16]), 32'(array_addr));
            chk("array data", 32'(exp_q[0][15:0]), 32'(array_wdata));
            void'(exp_q.pop_front());
         end
      end
   end
   initial begin
      #2_000_000;
      err_count++;
      end_of_test();
   end
   // ===========================================================
   // main sequence
   initial begin
      sys_rst = 1'b1;
      void'($urandom(32'h359b));
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_STATUS, st);
      chk("reset status", 32'h80, st);
      chk("bus response", 32'h0, 32'(hresp));
      rd(OFS_CTRL, st);
      chk("reset ctrl", 32'h4, st);
      rd(32'h20, st);
      chk("unmapped read", 32'h0, st);
      // failing entries: locked, bad supply, misaligned
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CTRL, fctl[i]);
         wr(OFS_ADDR, fadr[i]);
         cmd(16'(CMD_BF_SETUP));
         cmd(16'(CMD_CONFIRM));
         rd(OFS_STATUS, st);
         chk("ready during checks", 32'h0, 32'(st[SR_READY]));
         repeat (10) @(posedge clk);
         rd(OFS_STATUS, st);
         chk("failed entry", fexp[i], st & 32'hfff);
         cmd(16'(CMD_CLR_STATUS));
         rd(OFS_STATUS, st);
         chk("errors cleared", 32'h0, st & 32'h1f);
      end
      // full session: five buffers over a four-buffer block
      wr(OFS_CTRL, 32'h4);
      wr(OFS_ADDR, 32'h40);
      cmd(16'(CMD_BF_SETUP));
      cmd(16'(CMD_CONFIRM));
      repeat (10) @(posedge clk);
      rd(OFS_STATUS, st);
      chk("fill status", 32'h400, st & 32'hfff);
      for (int b = 0; b < 5; b++) begin
         for (int w = 0; w < BW; w++) begin
            d = 16'($urandom);
            cmd(d);
            exp_q.push_back({24'h40 + 24'((b * BW + w) % BLK), d});
         end
         rd(OFS_STATUS, st);
         chk("buffer busy", 32'h1, 32'(st[SR_BUSY]));
         cmd(16'(CMD_SUSPEND));
         // a second ignored write lands on the other half of the word counter
         cmd(16'(CMD_READ_STATUS));
         rd(OFS_STATUS, st);
         chk("bulk not suspended", 32'h0, 32'(st[SR_SUSP]));
         poll(32'h1 << SR_BUSY, 32'h0);
         chk("buffer drained", 32'h0, 32'(exp_q.size()));
      end
      // partial fill then leave by writing ones outside the block
      repeat (3) cmd(16'($urandom));
      wr(OFS_ADDR, 32'h80);
      cmd(PAD_WORD);
      repeat (4) @(posedge clk);
      rd(OFS_STATUS, st);
      chk("exit status", 32'h480, st & 32'hfff);
      // word program suspended, read modes, standby, resume
      wr(OFS_ADDR, 32'h123);
      cmd(16'(CMD_WORD_PROG));
      d = 16'($urandom);
      cmd(d);
      cmd(16'(CMD_SUSPEND));
      poll(32'h1 << SR_SUSP, 32'h1 << SR_SUSP);
      chk("suspend flags", 32'h84, st & 32'hff);
      for (int i = 0; i < 4; i++) begin
         cmd({8'h0, mcmd[i]});
         rd(OFS_STATUS, st);
         chk("read mode", 32'(i), 32'(st[11:10]));
      end
      cmd(16'(CMD_WORD_PROG));
      rd(OFS_STATUS, st);
      chk("still suspended", 32'h84, st & 32'hff);
      wr(OFS_CTRL, 32'h0);
      @(posedge clk);
      chk("standby", 32'h1, 32'(standby));
      wr(OFS_CTRL, 32'h4);
      exp_q.push_back({24'h123, d});
      cmd(16'(CMD_CONFIRM));
      rd(OFS_STATUS, st);
      chk("resumed flags", 32'h0, st & 32'h84);
      poll(32'h1 << SR_READY, 32'h1 << SR_READY);
      chk("word written", 32'h0, 32'(exp_q.size()));
      // reset while suspended: back to idle, nothing reaches the array
      cmd(16'(CMD_WORD_PROG));
      cmd(16'($urandom));
      cmd(16'(CMD_SUSPEND));
      poll(32'h1 << SR_SUSP, 32'h1 << SR_SUSP);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(OFS_STATUS, st);
      chk("status after reset", 32'h80, st);
      repeat (20) @(posedge clk);
      chk("no write after reset", 32'h0, 32'(exp_q.size()));
      end_of_test();
   end
endmodule : factory_buffer_program_suspend_tb_top
`default_nettype wire
